// [hw/csb_pkg.sv]
// Shared constants and types of the serial control bus block.
// Assumes a 250 MHz system clock and an open-drain pad ring outside.
package csb_pkg;
  // ****************************************
  // Strap decode
  // ****************************************
  localparam int STRAP_W = 3;
  localparam logic [6:0] DEV_ADDR [8] = '{7'h0c, 7'h0e, 7'h10, 7'h12, 7'h14, 7'h16, 7'h18, 7'h1a};

  // ****************************************
  // Register store and timing
  // ****************************************
  localparam int REG_AW = 8;
  localparam int REG_DW = 8;
  localparam logic [7:0] PTR_RESET = 8'h00;
  localparam int CLK_PERIOD_PS = 4000;
  localparam int CH_BIT_NS = 2500;
  // Quarter of a channel bit, rounded down, at least one cycle
  localparam int CH_QTR_RAW = (CH_BIT_NS * 1000 / 4) / CLK_PERIOD_PS;
  localparam int CH_QTR_CYC = (CH_QTR_RAW < 1) ? 1 : CH_QTR_RAW;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [1:0] LAST_BYTE = 2'h2;

  // ****************************************
  // State types
  // ****************************************
  typedef enum logic [2:0] {SLV_IDLE, SLV_ADDR, SLV_ADDR_ACK, SLV_WDATA, SLV_WACK, SLV_RDATA, SLV_RACK} csb_slv_e;
  typedef enum logic [2:0] {PM_IDLE, PM_WAIT, PM_START, PM_BIT, PM_STOP} csb_pm_e;
endpackage

// [hw/csb_mem_if.sv]
// Access port between the bus logic and the register store.
// Assumes both ends on clk_sys; one access per req cycle, ack one cycle later.
`timescale 1ns/1ps
interface csb_mem_if #(parameter int AW = 8, parameter int DW = 8);
  logic req;
  logic we;
  logic [AW-1:0] addr;
  logic [DW-1:0] wdata;
  logic [DW-1:0] rdata;
  logic ack;
  modport host (output req, output we, output addr, output wdata, input rdata, input ack);
  modport mem (input req, input we, input addr, input wdata, output rdata, output ack);
endinterface

// [hw/csb_reg_mem.sv]
// Register store of the device, single port with registered read data.
// Assumes the caller arbitrates so that only one access arrives per cycle.
`timescale 1ns/1ps
module csb_reg_mem
  import csb_pkg::*;
#(
  parameter int AW = REG_AW,
  parameter int DW = REG_DW
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Access port
  csb_mem_if.mem port
);
  logic [DW-1:0] store [2**AW];

  // Store write and registered read of the old value
  always_ff @(posedge clk_sys) begin
    if (port.req && port.we) begin
      store[port.addr] <= port.wdata;
    end
    port.rdata <= store[port.addr];
  end

  // One-cycle acknowledge
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      port.ack <= 1'b0;
    end else begin
      port.ack <= port.req;
    end
  end
endmodule

// [hw/csb_control_bus.sv]
// Serial control bus slave, register arbiter and proxy channel master.
// Assumes external pull-ups on both buses and a link-side request port on linkClk.
`timescale 1ns/1ps
module csb_control_bus
  import csb_pkg::*;
#(
  parameter int QTR_CYC = CH_QTR_CYC
) (
  // System clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Address strap level code
  input wire logic [STRAP_W-1:0] addrStrap,
  // Local serial control bus
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  // Bidirectional control channel bus
  input wire logic chSclIn,
  output logic chSclOut,
  output logic chSclOe,
  input wire logic chSdaIn,
  output logic chSdaOut,
  output logic chSdaOe,
  // Link-side request port
  input wire logic linkClk,
  input wire logic linkReqValid,
  output logic linkReqReady,
  input wire logic linkReqProxy,
  input wire logic linkReqWrite,
  input wire logic [6:0] linkReqTarget,
  input wire logic [REG_AW-1:0] linkReqAddr,
  input wire logic [REG_DW-1:0] linkReqData,
  output logic linkRespDone,
  output logic [REG_DW-1:0] linkRespData
);
  // ****************************************
  // Helpers and line synchronisers
  // ****************************************
  function automatic logic fallEdge(input logic p, input logic c);
    return p & ~c;
  endfunction

  function automatic logic riseEdge(input logic p, input logic c);
    return ~p & c;
  endfunction

  logic [3:0] lineMeta, lineSync, linePrev;
  logic [STRAP_W-1:0] strapMeta, strapSync;
  logic strapDone;
  logic [6:0] myAddr;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      lineMeta <= 4'hf;
      lineSync <= 4'hf;
      linePrev <= 4'hf;
    end else begin
      lineMeta <= {chSclIn, chSdaIn, sclIn, sdaIn};
      lineSync <= lineMeta;
      linePrev <= lineSync;
    end
  end

  always_ff @(posedge clk_sys) begin
    strapMeta <= addrStrap;
    strapSync <= strapMeta;
    if (sys_rst) begin
      strapDone <= 1'b0;
      myAddr <= 7'h00;
    end else if (!strapDone) begin
      strapDone <= 1'b1;
      myAddr <= DEV_ADDR[strapSync];
    end
  end

  logic sclS, sdaS, chSclS, chSdaS;
  logic startSeen, stopSeen, sclRise, sclFall, chStart, chStop;
  assign sclS = lineSync[1];
  assign sdaS = lineSync[0];
  assign chSclS = lineSync[3];
  assign chSdaS = lineSync[2];
  // start on SDA fall, SCL high
  assign startSeen = sclS & linePrev[1] & fallEdge(linePrev[0], sdaS);
  assign chStart = chSclS & linePrev[3] & fallEdge(linePrev[2], chSdaS);
  // stop on SDA rise, SCL high
  assign stopSeen = sclS & linePrev[1] & riseEdge(linePrev[0], sdaS);
  assign chStop = chSclS & linePrev[3] & riseEdge(linePrev[2], chSdaS);
  assign sclRise = riseEdge(linePrev[1], sclS);
  assign sclFall = fallEdge(linePrev[1], sclS);

  // ****************************************
  // Register arbiter
  // ****************************************
  csb_mem_if #(.AW(REG_AW), .DW(REG_DW)) memBus ();
  logic slvPend, slvWe, lnkPend, rrLink, ackToLink;
  logic [REG_AW-1:0] slvAddr;
  logic [REG_DW-1:0] slvWdata, slvRdHold;
  logic slvGrant, lnkGrant;
  logic lnkWrite, lnkProxy;
  logic [6:0] lnkTarget;
  logic [REG_AW-1:0] lnkAddr;
  logic [REG_DW-1:0] lnkData;

  assign slvGrant = slvPend & (~lnkPend | ~rrLink);
  assign lnkGrant = lnkPend & ~slvGrant;
  assign memBus.req = slvGrant | lnkGrant;
  assign memBus.we = slvGrant ? slvWe : lnkWrite;
  assign memBus.addr = slvGrant ? slvAddr : lnkAddr;
  assign memBus.wdata = slvGrant ? slvWdata : lnkData;

  csb_reg_mem #(.AW(REG_AW), .DW(REG_DW)) regStore (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .port(memBus.mem)
  );

  // Grant owner and fairness pointer
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      rrLink <= 1'b0;
      ackToLink <= 1'b0;
      slvRdHold <= 8'h00;
    end else begin
      ackToLink <= lnkGrant;
      if (slvGrant) begin
        rrLink <= 1'b1;
      end else if (lnkGrant) begin
        rrLink <= 1'b0;
      end
      if (memBus.ack && !ackToLink) begin
        slvRdHold <= memBus.rdata;
      end
    end
  end

  // ****************************************
  // Local bus slave
  // ****************************************
  csb_slv_e slvState;
  logic [3:0] slvBits;
  logic [7:0] slvShift, slvTx, slvPtr;
  logic slvRead, slvFirst, slvAcked, slvDrive;

  // Slave byte engine
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      slvState <= SLV_IDLE;
      slvBits <= 4'h0;
      slvShift <= 8'h00;
      slvTx <= 8'h00;
      slvPtr <= PTR_RESET;
      slvRead <= 1'b0;
      slvFirst <= 1'b0;
      slvAcked <= 1'b0;
      slvDrive <= 1'b0;
      slvPend <= 1'b0;
      slvWe <= 1'b0;
      slvAddr <= 8'h00;
      slvWdata <= 8'h00;
    end else begin
      if (slvGrant) begin
        slvPend <= 1'b0;
      end
      if (stopSeen) begin
        slvState <= SLV_IDLE;
        slvDrive <= 1'b0;
      end else if (startSeen) begin
        slvState <= SLV_ADDR;
        slvBits <= 4'h0;
        slvDrive <= 1'b0;
      end else begin
        unique case (slvState)
          SLV_IDLE: begin
            slvDrive <= 1'b0;
          end
          SLV_ADDR, SLV_WDATA: begin
            if (sclRise) begin
              slvShift <= {slvShift[6:0], sdaS};
              slvBits <= slvBits + 4'h1;
            end else if (sclFall && slvBits == BITS_PER_BYTE) begin
              slvBits <= 4'h0;
              if (slvState == SLV_ADDR) begin
                if (slvShift[7:1] == myAddr) begin
                  slvDrive <= 1'b1;
                  slvState <= SLV_ADDR_ACK;
                  slvRead <= slvShift[0];
                  if (slvShift[0]) begin
                    slvPend <= 1'b1;
                    slvWe <= 1'b0;
                    slvAddr <= slvPtr;
                    slvPtr <= slvPtr + 8'h01;
                  end
                end else begin
                  slvState <= SLV_IDLE;
                end
              end else begin
                slvDrive <= 1'b1;
                slvState <= SLV_WACK;
                slvFirst <= 1'b0;
                if (slvFirst) begin
                  slvPtr <= slvShift;
                end else begin
                  slvPend <= 1'b1;
                  slvWe <= 1'b1;
                  slvAddr <= slvPtr;
                  slvWdata <= slvShift;
                  slvPtr <= slvPtr + 8'h01;
                end
              end
            end
          end
          SLV_ADDR_ACK, SLV_WACK: begin
            if (sclFall) begin
              if (slvState == SLV_ADDR_ACK && slvRead) begin
                slvState <= SLV_RDATA;
                slvDrive <= ~slvRdHold[7];
                slvTx <= {slvRdHold[6:0], 1'b0};
                slvBits <= 4'h1;
              end else begin
                slvState <= SLV_WDATA;
                slvDrive <= 1'b0;
                slvFirst <= (slvState == SLV_ADDR_ACK);
                slvBits <= 4'h0;
              end
            end
          end
          SLV_RDATA: begin
            if (sclFall) begin
              if (slvBits == BITS_PER_BYTE) begin
                slvState <= SLV_RACK;
                slvDrive <= 1'b0;
              end else begin
                // a one is sent by releasing
                slvDrive <= ~slvTx[7];
                slvTx <= {slvTx[6:0], 1'b0};
                slvBits <= slvBits + 4'h1;
              end
            end
          end
          SLV_RACK: begin
            // master ack fetches the next byte
            if (sclRise) begin
              slvAcked <= ~sdaS;
              if (!sdaS) begin
                slvPend <= 1'b1;
                slvWe <= 1'b0;
                slvAddr <= slvPtr;
                slvPtr <= slvPtr + 8'h01;
              end
            end else if (sclFall) begin
              slvState <= slvAcked ? SLV_RDATA : SLV_IDLE;
              slvDrive <= slvAcked & ~slvRdHold[7];
              slvTx <= {slvRdHold[6:0], 1'b0};
              slvBits <= 4'h1;
            end
          end
        endcase
      end
    end
  end

  // ****************************************
  // Link request crossing
  // ****************************************
  logic lnkRstMeta, lnkRst, lnkBusy, reqTgl, doneMeta, doneSync, donePrev;
  logic reqMeta, reqSync, reqPrev, doneTgl, pmGo, pmDone, pmNack;
  logic [REG_DW-1:0] sysRespData;

  // Link-domain reset and request capture
  always_ff @(posedge linkClk) begin
    lnkRstMeta <= sys_rst;
    lnkRst <= lnkRstMeta;
    if (lnkRst) begin
      lnkBusy <= 1'b0;
      reqTgl <= 1'b0;
      {doneMeta, doneSync, donePrev} <= 3'h0;
      linkRespDone <= 1'b0;
      linkRespData <= 8'h00;
      {lnkProxy, lnkWrite, lnkTarget, lnkAddr, lnkData} <= 25'h0;
    end else begin
      doneMeta <= doneTgl;
      doneSync <= doneMeta;
      donePrev <= doneSync;
      linkRespDone <= doneSync ^ donePrev;
      if (doneSync ^ donePrev) begin
        lnkBusy <= 1'b0;
        linkRespData <= sysRespData;
      end else if (linkReqValid && !lnkBusy) begin
        lnkBusy <= 1'b1;
        reqTgl <= ~reqTgl;
        {lnkProxy, lnkWrite, lnkTarget} <= {linkReqProxy, linkReqWrite, linkReqTarget};
        {lnkAddr, lnkData} <= {linkReqAddr, linkReqData};
      end
    end
  end
  assign linkReqReady = ~lnkBusy;

  // System-domain request event and answer
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      {reqMeta, reqSync, reqPrev} <= 3'h0;
      doneTgl <= 1'b0;
      lnkPend <= 1'b0;
      pmGo <= 1'b0;
      sysRespData <= 8'h00;
    end else begin
      reqMeta <= reqTgl;
      reqSync <= reqMeta;
      reqPrev <= reqSync;
      pmGo <= (reqSync ^ reqPrev) & lnkProxy;
      if (lnkGrant) begin
        lnkPend <= 1'b0;
      end else if ((reqSync ^ reqPrev) && !lnkProxy) begin
        lnkPend <= 1'b1;
      end
      if (memBus.ack && ackToLink) begin
        sysRespData <= memBus.rdata;
        doneTgl <= ~doneTgl;
      end else if (pmDone) begin
        sysRespData <= {7'h00, pmNack};
        doneTgl <= ~doneTgl;
      end
    end
  end

  // ****************************************
  // Proxy master on the control channel
  // ****************************************
  csb_pm_e pmState;
  logic [1:0] pmPhase, pmByte;
  logic [3:0] pmBit;
  logic [15:0] pmCnt;
  logic pmSclLow, pmSdaLow, busBusy, pmHold, pmTick;
  logic [7:0] pmTxByte;
  logic pmLost;

  assign pmTxByte = (pmByte == 2'h0) ? {lnkTarget, 1'b0} : ((pmByte == 2'h1) ? lnkAddr : lnkData);
  assign pmHold = (pmPhase == 2'h2) & ~chSclS & ((pmState == PM_BIT) | (pmState == PM_STOP));
  assign pmTick = (pmCnt == 16'h0) & ~pmHold;
  // driving one but line reads zero
  assign pmLost = (pmState == PM_BIT) & (pmPhase == 2'h2) & (pmBit != BITS_PER_BYTE) & ~pmSdaLow & chSclS & ~chSdaS;

  // Channel busy tracker and quarter-bit timer
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      busBusy <= 1'b0;
      pmCnt <= 16'h0;
    end else begin
      busBusy <= chStart | (busBusy & ~chStop);
      if (pmState == PM_IDLE || pmTick) begin
        pmCnt <= 16'(QTR_CYC - 1);
      end else if (!pmHold && pmCnt != 16'h0) begin
        pmCnt <= pmCnt - 16'h1;
      end
    end
  end

  // Proxy master sequencer
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      pmState <= PM_IDLE;
      {pmPhase, pmByte, pmBit} <= 8'h0;
      {pmSclLow, pmSdaLow, pmNack, pmDone} <= 4'h0;
    end else begin
      pmDone <= 1'b0;
      unique case (pmState)
        PM_IDLE: begin
          if (pmGo) begin
            pmState <= PM_WAIT;
            pmNack <= 1'b0;
          end
        end
        PM_WAIT: begin
          // start by pulling SDA under high SCL
          if (pmTick && !busBusy && chSclS && chSdaS) begin
            pmState <= PM_START;
            pmSdaLow <= 1'b1;
          end
        end
        PM_START: begin
          if (pmTick) begin
            pmSclLow <= 1'b1;
            pmState <= PM_BIT;
            {pmPhase, pmByte, pmBit} <= 8'h0;
          end
        end
        PM_BIT: begin
          if (pmLost) begin
            pmSdaLow <= 1'b0;
            pmSclLow <= 1'b0;
            pmState <= PM_WAIT;
          end else if (pmTick) begin
            pmPhase <= pmPhase + 2'h1;
            unique case (pmPhase)
              2'h0: pmSdaLow <= (pmBit != BITS_PER_BYTE) & ~pmTxByte[3'(7 - pmBit)];
              2'h1: pmSclLow <= 1'b0;
              2'h2: pmNack <= (pmBit == BITS_PER_BYTE) ? chSdaS : pmNack;
              2'h3: begin
                pmSclLow <= 1'b1;
                pmBit <= pmBit + 4'h1;
                if (pmBit == BITS_PER_BYTE) begin
                  pmBit <= 4'h0;
                  pmByte <= pmByte + 2'h1;
                  if (pmNack || pmByte == LAST_BYTE) begin
                    pmState <= PM_STOP;
                  end
                end
              end
            endcase
          end
        end
        PM_STOP: begin
          if (pmTick) begin
            pmPhase <= pmPhase + 2'h1;
            unique case (pmPhase)
              2'h0: pmSdaLow <= 1'b1;
              2'h1: pmSclLow <= 1'b0;
              2'h2: pmSdaLow <= 1'b1;
              // stop by releasing SDA under high SCL
              2'h3: begin
                pmSdaLow <= 1'b0;
                pmDone <= 1'b1;
                pmState <= PM_IDLE;
              end
            endcase
          end
        end
      endcase
    end
  end

  // ****************************************
  // Pin drivers
  // ****************************************
  // open-drain, data always low
  assign sdaOut = 1'b0;
  assign sdaOe = slvDrive;
  assign chSclOut = 1'b0;
  assign chSclOe = pmSclLow;
  assign chSdaOut = 1'b0;
  assign chSdaOe = pmSdaLow;
endmodule

// [testbench/csb_control_bus_assertions.sv]
// Port-level checks of the control bus block.
// Assumes bus lines resolved by the bench; bound to every csb_control_bus.
`timescale 1ns/1ps
module csb_control_bus_assertions
  import csb_pkg::*;
(
  // Clocks and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic linkClk,
  // Local bus
  input wire logic sclIn,
  input wire logic sdaIn,
  input wire logic sdaOut,
  input wire logic sdaOe,
  // Channel bus
  input wire logic chSclIn,
  input wire logic chSclOut,
  input wire logic chSclOe,
  input wire logic chSdaIn,
  input wire logic chSdaOut,
  input wire logic chSdaOe,
  // Link port
  input wire logic linkReqValid,
  input wire logic linkReqReady,
  input wire logic linkRespDone,
  input wire logic [REG_DW-1:0] linkRespData
);
  logic sdaQ, chSclQ, chSdaQ, busIdle;
  logic [3:0] chBit;
  // Line events and lost arbitration
  wire startL = sclIn && sdaQ && !sdaIn;
  wire stopL = sclIn && !sdaQ && sdaIn;
  wire startC = chSclIn && chSdaQ && !chSdaIn;
  wire arbLost = chSclQ && chSclIn && !chSdaIn && !chSdaOe && (chBit < 4'h8);
  // Line history, idle flag, channel bit count
  always_ff @(posedge clk_sys) begin
    sdaQ <= sdaIn;
    chSclQ <= chSclIn;
    chSdaQ <= chSdaIn;
    if (sys_rst || stopL) begin
      busIdle <= 1'b1;
    end else if (startL) begin
      busIdle <= 1'b0;
    end
    if (sys_rst || startC) begin
      chBit <= 4'hf;
    end else if (chSclQ && !chSclIn) begin
      chBit <= (chBit == 4'h8) ? 4'h0 : chBit + 4'h1;
    end
  end
  // ****
  // Assertions
  // ****
  a_open_drain: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !sdaOut && !chSclOut && !chSdaOut) else $error("pin output not low");
  a_sda_scl_low: assert property (@(posedge clk_sys) disable iff (sys_rst)
    $changed(sdaOe) |-> !sclIn) else $error("slave moved SDA with SCL high");
  a_no_ack_idle: assert property (@(posedge clk_sys) disable iff (sys_rst)
    $rose(sdaOe) |-> !busIdle) else $error("slave drove SDA outside a frame");
  a_arb_release: assert property (@(posedge clk_sys) disable iff (sys_rst)
    arbLost |-> ##[1:8] (!chSdaOe && !chSclOe)) else $error("proxy kept lines after loss");
  a_take_busy: assert property (@(posedge linkClk) disable iff (sys_rst)
    linkReqValid && linkReqReady |=> !linkReqReady) else $error("ready stayed high after take");
  a_done_ready: assert property (@(posedge linkClk) disable iff (sys_rst)
    linkRespDone |-> linkReqReady) else $error("ready low at done");
  a_done_pulse: assert property (@(posedge linkClk) disable iff (sys_rst)
    linkRespDone |=> !linkRespDone) else $error("done longer than one cycle");
  a_resp_hold: assert property (@(posedge linkClk) disable iff (sys_rst)
    !linkRespDone |-> $stable(linkRespData)) else $error("response data moved");
  // Main scenarios reached
  c_arb: cover property (@(posedge clk_sys) arbLost);
  c_ack: cover property (@(posedge clk_sys) $rose(sdaOe));
  c_done: cover property (@(posedge linkClk) linkRespDone);
endmodule

bind csb_control_bus csb_control_bus_assertions i_chk (.clk_sys(clk_sys), .sys_rst(sys_rst),
  .linkClk(linkClk), .sclIn(sclIn), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe),
  .chSclIn(chSclIn), .chSclOut(chSclOut), .chSclOe(chSclOe), .chSdaIn(chSdaIn),
  .chSdaOut(chSdaOut), .chSdaOe(chSdaOe), .linkReqValid(linkReqValid),
  .linkReqReady(linkReqReady), .linkRespDone(linkRespDone), .linkRespData(linkRespData));

// [testbench/csb_ch_partner.sv]
// Far end of the control channel: remote slave and a rival master.
// Assumes pull-ups on both lines; device enables are pull-low requests.
`timescale 1ns/1ps
module csb_ch_partner (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Device pull-low requests
  input wire logic chSclOe,
  input wire logic chSdaOe,
  // Behaviour selects
  input wire logic contend,
  input wire logic nackAll,
  input wire logic stretch,
  // Resolved lines and receive log
  output logic chSclIn,
  output logic chSdaIn,
  output logic [7:0] nStart,
  output logic [23:0] rxLog
);
  logic pScl, pSda, sclQ, sdaQ, grab, used;
  logic [3:0] bitCnt;
  logic [7:0] sh;
  logic [5:0] hold;
  assign chSclIn = !(chSclOe || pScl);
  assign chSdaIn = !(chSdaOe || pSda);
  wire startEv = sclQ && chSclIn && sdaQ && !chSdaIn;
  wire sclFall = sclQ && !chSclIn;
  wire sclRise = !sclQ && chSclIn;
  // Slave receive, ack, stretch and rival hold
  always_ff @(posedge clk_sys) begin
    sclQ <= chSclIn;
    sdaQ <= chSdaIn;
    if (sys_rst) begin
      pScl <= 1'b0;
      pSda <= 1'b0;
      nStart <= 8'h00;
      rxLog <= 24'h0;
      used <= 1'b0;
      grab <= 1'b0;
      hold <= 6'h00;
      bitCnt <= 4'h0;
    end else if (startEv) begin
      nStart <= nStart + 8'h01;
      bitCnt <= 4'hf; // Start fall is no data bit
      grab <= contend && !used;
    end else if (sclRise) begin
      sh <= {sh[6:0], chSdaIn};
    end else if (sclFall && grab) begin
      // rival pulls SDA low, releases it when hold has counted down from 6'h28
      pSda <= 1'b1;
      hold <= 6'h28;
      grab <= 1'b0;
      used <= 1'b1;
    end else if (sclFall && bitCnt == 4'h7) begin
      pSda <= !nackAll;
      rxLog <= {rxLog[15:0], sh};
      bitCnt <= 4'h8;
    end else if (sclFall && bitCnt == 4'h8) begin
      // optional low hold of SCL after ack
      pSda <= 1'b0;
      pScl <= stretch;
      hold <= 6'h18;
      bitCnt <= 4'h0;
    end else if (sclFall) begin
      bitCnt <= bitCnt + 4'h1;
    end else if (hold != 6'h00) begin
      hold <= hold - 6'h01;
      if (hold == 6'h01) begin
        pScl <= 1'b0;
        pSda <= 1'b0;
      end
    end
  end
endmodule

// [testbench/csb_control_bus_tb.sv]
// Self-checking bench of the control bus block.
// Assumes the checker is bound; the partner model sits on the channel.
`timescale 1ns/1ps
module csb_control_bus_tb;
  localparam logic [6:0] MY = 7'h1a;
  logic clk_sys, sys_rst, linkClk, hostScl, hostSda, sdaOut, sdaOe;
  logic chSclIn, chSdaIn, chSclOut, chSclOe, chSdaOut, chSdaOe;
  logic linkReqValid, linkReqReady, linkReqProxy, linkReqWrite, linkRespDone;
  logic contend, nackAll, stretch;
  logic [2:0] addrStrap;
  logic [6:0] linkReqTarget;
  logic [7:0] linkReqAddr, linkReqData, linkRespData, nStart;
  logic [23:0] rxLog;
  int n_errors, n_tests;
  // Local bus with pull-up
  wire sclIn = hostScl;
  wire sdaIn = hostSda && !sdaOe;
  csb_control_bus #(.QTR_CYC(4)) i_dut (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .addrStrap(addrStrap), .sclIn(sclIn), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe),
    .chSclIn(chSclIn), .chSclOut(chSclOut), .chSclOe(chSclOe), .chSdaIn(chSdaIn),
    .chSdaOut(chSdaOut), .chSdaOe(chSdaOe), .linkClk(linkClk), .linkReqValid(linkReqValid),
    .linkReqReady(linkReqReady), .linkReqProxy(linkReqProxy), .linkReqWrite(linkReqWrite),
    .linkReqTarget(linkReqTarget), .linkReqAddr(linkReqAddr), .linkReqData(linkReqData),
    .linkRespDone(linkRespDone), .linkRespData(linkRespData));
  csb_ch_partner i_far (.clk_sys(clk_sys), .sys_rst(sys_rst), .chSclOe(chSclOe),
    .chSdaOe(chSdaOe), .contend(contend), .nackAll(nackAll), .stretch(stretch),
    .chSclIn(chSclIn), .chSdaIn(chSdaIn), .nStart(nStart), .rxLog(rxLog));
  // Clocks
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = !clk_sys;
  end
  initial begin
    linkClk = 1'b0;
    #5.3;
    forever #16 linkClk = !linkClk;
  end
  // ****
  // Helpers
  // ****
  task automatic print_verdict;
    if (n_errors == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  task automatic do_reset;
    sys_rst = 1'b1;
    repeat (3) @(negedge linkClk);
    @(negedge clk_sys);
    sys_rst = 1'b0;
    repeat (6) @(negedge linkClk);
  endtask
  task automatic bit_io(input logic b, output logic s);
    hostSda = b;
    cyc(8);
    hostScl = 1'b1;
    cyc(4);
    s = sdaIn;
    cyc(4);
    hostScl = 1'b0;
    cyc(4);
  endtask
  task automatic start_c;
    hostSda = 1'b1;
    cyc(4);
    hostScl = 1'b1;
    cyc(8);
    hostSda = 1'b0;
    cyc(8);
    hostScl = 1'b0;
    cyc(4);
  endtask
  task automatic stop_c;
    hostSda = 1'b0;
    cyc(4);
    hostScl = 1'b1;
    cyc(8);
    hostSda = 1'b1;
    cyc(8);
  endtask
  // Sends a byte; returns the ninth slot level
  task automatic tx(input logic [7:0] d, output logic n);
    for (int i = 7; i >= 0; i--) bit_io(d[i], n);
    bit_io(1'b1, n);
  endtask
  task automatic rx(input logic last, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, s);
      d[i] = s;
    end
    bit_io(last, s);
  endtask
  task automatic loc_wr(input logic [7:0] p, input logic [7:0] d0, input logic [7:0] d1);
    logic [3:0] n;
    start_c();
    tx({MY, 1'b0}, n[3]);
    tx(p, n[2]);
    tx(d0, n[1]);
    tx(d1, n[0]);
    stop_c();
    chk("write acks", 24'h0, 24'(n));
  endtask
  task automatic loc_rd(input logic [7:0] p, output logic [7:0] d0, output logic [7:0] d1);
    logic [2:0] n;
    start_c();
    tx({MY, 1'b0}, n[2]);
    tx(p, n[1]);
    start_c();
    tx({MY, 1'b1}, n[0]);
    rx(1'b0, d0);
    rx(1'b1, d1);
    stop_c();
    chk("read acks", 24'h0, 24'(n));
  endtask
  task automatic link(input logic px, input logic wr, input logic [7:0] a, input logic [7:0] d,
      output logic [7:0] r);
    int k;
    @(negedge linkClk);
    for (k = 0; k < 200 && linkReqReady !== 1'b1; k++) @(negedge linkClk);
    linkReqProxy = px;
    linkReqWrite = wr;
    linkReqAddr = a;
    linkReqData = d;
    linkReqValid = 1'b1;
    @(negedge linkClk);
    linkReqValid = 1'b0;
    for (k = 0; k < 3000 && linkRespDone !== 1'b1; k++) @(negedge linkClk);
    r = linkRespData;
    chk("link done", 24'h1, 24'(linkRespDone));
  endtask
  // ****
  // Scenarios
  // ****
  task automatic sc_strap;
    logic n;
    for (int c = 0; c < 8; c++) begin
      addrStrap = 3'(c);
      do_reset();
      start_c();
      tx({7'h0c + 7'(2 * c), 1'b0}, n);
      stop_c();
      chk("own address", 24'h0, 24'(n));
      start_c();
      tx({7'h0d + 7'(2 * c), 1'b0}, n);
      stop_c();
      chk("foreign address", 24'h1, 24'(n));
    end
  endtask
  task automatic sc_local;
    logic [7:0] a, b;
    loc_wr(8'h10, 8'ha5, 8'h3c);
    loc_rd(8'h10, a, b);
    chk("local pair", 24'h00a53c, {8'h0, a, b});
  endtask
  task automatic sc_mixed;
    logic [7:0] r1, r2, a, b;
    fork
      loc_wr(8'h20, 8'h11, 8'h22);
      link(1'b0, 1'b1, 8'h30, 8'h77, r1);
    join
    link(1'b0, 1'b0, 8'h20, 8'h00, r1);
    link(1'b0, 1'b0, 8'h21, 8'h00, r2);
    loc_rd(8'h30, a, b);
    chk("mixed access", 24'h112277, {r1, r2, a});
  endtask
  task automatic sc_proxy;
    logic [7:0] r, s0;
    for (int m = 0; m < 3; m++) begin
      stretch = (m == 0);
      nackAll = (m == 1);
      contend = (m == 2);
      s0 = nStart;
      link(1'b1, 1'b1, 8'h40 + 8'(m), 8'hc3, r);
      chk("proxy status", 24'(m == 1), 24'(r));
      chk("proxy starts", 24'(s0) + 24'(1 + (m == 2)), 24'(nStart));
      if (m != 1) chk("proxy bytes", {16'ha040 + 16'(m), 8'hc3}, rxLog);
    end
  endtask
  // Main sequence
  initial begin
    sys_rst = 1'b1;
    hostScl = 1'b1;
    hostSda = 1'b1;
    addrStrap = 3'h0;
    linkReqValid = 1'b0;
    linkReqProxy = 1'b0;
    linkReqWrite = 1'b0;
    linkReqTarget = 7'h50;
    linkReqAddr = 8'h00;
    linkReqData = 8'h00;
    contend = 1'b0;
    nackAll = 1'b0;
    stretch = 1'b0;
    n_errors = 0;
    n_tests = 0;
    sc_strap();
    sc_local();
    sc_mixed();
    sc_proxy();
    print_verdict();
  end
  // Watchdog
  initial begin
    repeat (60000) @(posedge clk_sys);
    n_errors++;
    print_verdict();
  end
endmodule
